//--- rtl/ntaf_pkg.sv
// Purpose: Shared constants and codes for the network termination activation
//          state machine.
// Assumes: One 10 MHz clock.
// Notes:   Signal codes are the block's own encodings.
package ntaf_pkg;

  localparam int CLK_HZ = 10000000;

  // Awake supervision timer, in milliseconds.
  localparam int TN1_MS     = 13;
  localparam int TN1_CYCLES = (CLK_HZ / 1000) * TN1_MS;

  // Deactivation timer default, in milliseconds.
  localparam int T2_MS     = 25;
  localparam int T2_CYCLES = (CLK_HZ / 1000) * T2_MS;

  // Framing acquisition and loss thresholds, in frames.
  localparam int FRM_ACQ      = 4;
  localparam int FRM_LOSS     = 100;
  localparam int FRM_LOSS_MIN = 60;
  localparam int FRM_LOSS_MAX = 200;
  localparam int FRM_CW       = 8;

  // Received line signal codes.
  typedef enum logic [3:0] {
    RX_SIG0    = 4'h0,
    RX_SIG2W   = 4'h1,
    RX_SIG2    = 4'h2,
    RX_SIG4H   = 4'h3,
    RX_SIG4    = 4'h4,
    RX_SIG2L2  = 4'h5,
    RX_SIG4HL2 = 4'h6,
    RX_SIG4L2  = 4'h7,
    RX_NONE    = 4'hf
  } ntaf_rxsig_t;

  // Transmitted line signal codes.
  typedef enum logic [2:0] {
    TX_SIG0  = 3'h0,
    TX_SIG1W = 3'h1,
    TX_SIG1A = 3'h2,
    TX_SIG1  = 3'h3,
    TX_SIG3  = 3'h4,
    TX_SIG5  = 3'h5
  } ntaf_txsig_t;

  // Received user side codes.
  typedef enum logic [1:0] {
    UI_INFO0 = 2'h0,
    UI_INFO1 = 2'h1,
    UI_INFO3 = 2'h2,
    UI_OTHER = 2'h3
  } ntaf_uinfo_t;

  // Transmitted user side codes.
  typedef enum logic [2:0] {
    UO_INFO0 = 3'h0,
    UO_INFO2 = 3'h1,
    UO_INFO4 = 3'h2,
    UO_INFOX = 3'h3
  } ntaf_uout_t;

endpackage : ntaf_pkg

//--- rtl/ntaf_frame_mon.sv
// Purpose: Line framing monitor, one check result per frame.
// Assumes: frame_tick_i pulses once per frame with match_i valid.
// Notes:   Loss threshold is a parameter inside the allowed window.
module ntaf_frame_mon
  import ntaf_pkg::*;
#(
  parameter int ACQ  = FRM_ACQ,
  parameter int LOSS = FRM_LOSS
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Frame word check.
  input  wire logic frame_tick_i,
  input  wire logic match_i,
  input  wire logic enable_i,
  // Status.
  output logic      locked_o
);

  // The counter must hold the largest threshold minus one.
  if (LOSS < FRM_LOSS_MIN || LOSS > FRM_LOSS_MAX ||
      ACQ < 1 || ACQ > 2 ** FRM_CW) begin : g_bad_cfg
    $error("ntaf_frame_mon: threshold out of range");
  end

  logic [FRM_CW-1:0] cnt;
  logic [FRM_CW-1:0] next_cnt;
  logic              next_locked;

  // Lock after ACQ good frames in a row, drop after LOSS bad ones.
  always_comb begin
    next_cnt    = cnt;
    next_locked = locked_o;
    if (!enable_i) begin
      next_cnt    = '0;
      next_locked = 1'b0;
    end else if (frame_tick_i) begin
      if (locked_o == match_i) begin
        next_cnt = '0;
      end else if (cnt == FRM_CW'(locked_o ? LOSS - 1 : ACQ - 1)) begin
        next_cnt    = '0;
        next_locked = !locked_o;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt      <= '0;
      locked_o <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      locked_o <= next_locked;
    end
  end

endmodule : ntaf_frame_mon

//--- rtl/ntaf_fsm.sv
// What this block does
// - Deactivated state sends nothing to user and line.
// - User wake request enters awake send, then waits line awake tone.
// - Line awake tone in deactivated state starts awake timer; expiry leads to unframed send.
// - Sync state sends unframed signal, moves on when line signal detected.
// - Line-synced state sends framed line signal and user signal, waits.
// - Both-way synced state sends user signal two and SIG 3.
// - Fully active sends INFO 4 and SIG 5, carrying traffic.
// - Line silence from sync onward starts T2, pending deactivation.
// - Pending deactivation ends on user silence or T2 expiry.
// - User loss in active goes to user-fault state, INFO 3 returns.
// - Line framing loss enters line-fault state sending INFO X, SIG 0.
// - INFO X is unframed all zeros.
// - Loopback request in sync states enters loopback wait.
// - Loopback full request enters loopback active, data looped.
// - Loopback active forces D-echo bit to zero.
// - Awake timer lasts 13 ms.
// - Framing acquired after 4 frames, lost after 60 to 200.
//
// Purpose: Activation and deactivation control of the network termination.
// Assumes: Receive codes are decoded and synchronous to clk_i.
// Notes:   Timers are parameters so simulation can shorten them.
module ntaf_fsm
  import ntaf_pkg::*;
#(
  parameter int TN1_CNT = TN1_CYCLES,
  parameter int T2_CNT  = T2_CYCLES,
  parameter int LOSS    = FRM_LOSS
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Line receive side.
  input  wire ntaf_rxsig_t line_rx_i,
  input  wire logic        line_frame_tick_i,
  input  wire logic        line_frame_match_i,
  // User receive side.
  input  wire ntaf_uinfo_t user_rx_i,
  input  wire logic        user_frame_lost_i,
  // Transmit selection.
  output ntaf_txsig_t      line_tx_o,
  output ntaf_uout_t       user_tx_o,
  output logic             user_framed_o,
  output logic             decho_zero_o,
  output logic             loop_2bd_o,
  output logic             traffic_o,
  output logic [3:0]       state_o
);

  if (TN1_CNT < 1 || T2_CNT < 1) begin : g_bad_timer
    $error("ntaf_fsm: timer counts must be positive");
  end

  typedef enum logic [11:0] {
    S_DEACT = 12'h001, S_AWAKE = 12'h002, S_ANSW = 12'h004,
    S_SYNC  = 12'h008, S_LSYNC = 12'h010, S_USYNC = 12'h020,
    S_ACT   = 12'h040, S_PEND  = 12'h080, S_UFLT  = 12'h100,
    S_LFLT  = 12'h200, S_LBW   = 12'h400, S_LBA   = 12'h800
  } ntaf_state_t;

  ntaf_state_t state;
  ntaf_state_t next_state;
  logic [31:0] tmr;
  logic [31:0] next_tmr;
  logic        line_locked;
  logic        lock_seen;
  logic        next_lock_seen;
  ntaf_txsig_t next_line_tx;
  ntaf_uout_t  next_user_tx;
  logic [3:0]  next_state_o;
  logic        next_framed;
  logic        next_decho;
  logic        next_loop;
  logic        next_traffic;

  ntaf_frame_mon #(.ACQ(FRM_ACQ), .LOSS(LOSS)) u_frm (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .frame_tick_i (line_frame_tick_i),
    .match_i      (line_frame_match_i),
    .enable_i     (state != S_DEACT && state != S_PEND),
    .locked_o     (line_locked)
  );

  // Framing loss is only meaningful once lock has been held.
  wire logic lost_line = lock_seen && !line_locked;
  wire logic on_from_sync = !(state inside {S_DEACT, S_AWAKE, S_ANSW,
                                            S_PEND});

  function automatic logic [3:0] st_idx(input ntaf_state_t s);
    for (int i = 0; i < 12; i++)
      if (s[i]) return 4'(i);
    return 4'h0;
  endfunction : st_idx

  always_comb begin
    next_state     = state;
    next_tmr       = (tmr != 32'h0) ? tmr - 32'h1 : 32'h0;
    next_lock_seen = lock_seen | line_locked;
    if (on_from_sync && line_rx_i == RX_SIG0) begin
      next_state = S_PEND;
      next_tmr   = 32'(T2_CNT);
    end else if (lost_line && (state inside {S_LSYNC, S_USYNC, S_ACT,
                                             S_UFLT, S_LBW, S_LBA})) begin
      next_state = S_LFLT;
    end else begin
      case (state)
        S_DEACT: begin
          if (line_rx_i == RX_SIG2W) begin
            next_state = S_ANSW;
            next_tmr   = 32'(TN1_CNT);
          end else if (user_rx_i == UI_INFO1) begin
            next_state = S_AWAKE;
          end
        end
        S_AWAKE: if (line_rx_i == RX_SIG2W) next_state = S_SYNC;
        S_ANSW: begin
          if (line_rx_i == RX_SIG2W) next_tmr = 32'(TN1_CNT);
          else if (tmr == 32'h1) next_state = S_SYNC;
        end
        S_SYNC: begin
          if (line_rx_i == RX_SIG2L2) next_state = S_LBW;
          else if (line_rx_i == RX_SIG2 && line_locked)
            next_state = S_LSYNC;
        end
        S_LSYNC: begin
          if (line_rx_i == RX_SIG2L2) next_state = S_LBW;
          else if (user_rx_i == UI_INFO3) next_state = S_USYNC;
        end
        S_USYNC: begin
          if (line_rx_i == RX_SIG2L2) next_state = S_LBW;
          else if (line_rx_i == RX_SIG4H) next_state = S_ACT;
          else if (line_rx_i == RX_SIG4HL2) next_state = S_LBA;
        end
        S_ACT: begin
          if (line_rx_i == RX_SIG4L2) next_state = S_LBA;
          else if (user_rx_i == UI_INFO0 || user_frame_lost_i)
            next_state = S_UFLT;
        end
        S_PEND: begin
          if (user_rx_i == UI_INFO0 || tmr == 32'h1)
            next_state = S_DEACT;
        end
        S_UFLT: begin
          if (line_rx_i == RX_SIG4L2) next_state = S_LBA;
          else if (user_rx_i == UI_INFO3) next_state = S_ACT;
        end
        S_LFLT: if (line_rx_i == RX_SIG4L2) next_state = S_LBA;
        S_LBW: begin
          if (line_rx_i == RX_SIG4HL2) next_state = S_LBA;
          else if (line_rx_i == RX_SIG4H) next_state = S_ACT;
        end
        S_LBA: if (line_rx_i == RX_SIG4) next_state = S_ACT;
        default: next_state = S_DEACT;
      endcase
    end
    if (next_state == S_DEACT || next_state == S_PEND)
      next_lock_seen = 1'b0;
  end

  // Outputs follow the next state so they change with the state itself.
  always_comb begin
    next_line_tx = TX_SIG0;
    next_user_tx = UO_INFO0;
    case (next_state)
      S_DEACT: begin
        next_line_tx = TX_SIG0;
        next_user_tx = UO_INFO0;
      end
      S_AWAKE: next_line_tx = TX_SIG1W;
      S_ANSW:  next_line_tx = TX_SIG1W;
      S_SYNC:  next_line_tx = TX_SIG1A;
      S_LSYNC: begin
        next_line_tx = TX_SIG1;
        next_user_tx = UO_INFO2;
      end
      S_USYNC: begin
        next_line_tx = TX_SIG3;
        next_user_tx = UO_INFO2;
      end
      S_ACT: begin
        next_line_tx = TX_SIG5;
        next_user_tx = UO_INFO4;
      end
      S_PEND:  next_line_tx = TX_SIG0;
      S_UFLT: begin
        next_line_tx = TX_SIG5;
        next_user_tx = UO_INFO2;
      end
      S_LFLT: begin
        next_line_tx = TX_SIG0;
        next_user_tx = UO_INFOX;
      end
      S_LBW: begin
        next_line_tx = TX_SIG3;
        next_user_tx = UO_INFO2;
      end
      S_LBA: begin
        next_line_tx = TX_SIG5;
        next_user_tx = UO_INFO4;
      end
      default: next_line_tx = TX_SIG0;
    endcase
    next_state_o = st_idx(next_state);
    next_framed  = next_user_tx != UO_INFO0 &&
                   next_user_tx != UO_INFOX;
    next_decho   = next_state == S_LBA;
    next_loop    = next_state == S_LBA;
    next_traffic = next_state == S_ACT;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state         <= S_DEACT;
      tmr           <= 32'h0;
      lock_seen     <= 1'b0;
      line_tx_o     <= TX_SIG0;
      user_tx_o     <= UO_INFO0;
      user_framed_o <= 1'b0;
      decho_zero_o  <= 1'b0;
      loop_2bd_o    <= 1'b0;
      traffic_o     <= 1'b0;
      state_o       <= 4'h0;
    end else begin
      state         <= next_state;
      tmr           <= next_tmr;
      lock_seen     <= next_lock_seen;
      line_tx_o     <= next_line_tx;
      user_tx_o     <= next_user_tx;
      user_framed_o <= next_framed;
      decho_zero_o  <= next_decho;
      loop_2bd_o    <= next_loop;
      traffic_o     <= next_traffic;
      state_o       <= next_state_o;
    end
  end

  chk_tn1_expiry: assert property (@(posedge clk_i) disable iff (rst_i)
    state == S_ANSW && tmr == 32'h1 && line_rx_i != RX_SIG2W &&
    line_rx_i != RX_SIG0 |=> line_tx_o == TX_SIG1A)
    else $error("awake timer expiry did not start unframed send");
  chk_deact_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    state == S_DEACT |-> line_tx_o == TX_SIG0 && user_tx_o == UO_INFO0)
    else $error("deactivated state is transmitting");
  chk_sig0_pend: assert property (@(posedge clk_i) disable iff (rst_i)
    on_from_sync && line_rx_i == RX_SIG0 |=> state == S_PEND &&
    tmr == 32'(T2_CNT))
    else $error("line silence did not start pending deactivation");
  chk_pend_exit: assert property (@(posedge clk_i) disable iff (rst_i)
    state == S_PEND && user_rx_i == UI_INFO0 |=> state == S_DEACT)
    else $error("pending deactivation did not end on user silence");
  chk_infox_unfr: assert property (@(posedge clk_i) disable iff (rst_i)
    user_tx_o == UO_INFOX |-> !user_framed_o)
    else $error("fault signal is framed");
  chk_loop_echo: assert property (@(posedge clk_i) disable iff (rst_i)
    state == S_LBA |-> decho_zero_o && loop_2bd_o &&
    user_tx_o == UO_INFO4)
    else $error("loopback active outputs wrong");
  chk_ufault_go: assert property (@(posedge clk_i) disable iff (rst_i)
    state == S_ACT && user_rx_i == UI_INFO0 && line_rx_i == RX_SIG4 &&
    !lost_line |=> state == S_UFLT && line_tx_o == TX_SIG5)
    else $error("user loss not handled");
  chk_lfault_go: assert property (@(posedge clk_i) disable iff (rst_i)
    state == S_ACT && lost_line && line_rx_i != RX_SIG0 |=>
    state == S_LFLT ##0 user_tx_o == UO_INFOX)
    else $error("line framing loss not handled");

  cov_full_act: cover property (@(posedge clk_i) state == S_ACT);
  cov_loop_act: cover property (@(posedge clk_i) state == S_LBA);
  cov_deact_ret: cover property (@(posedge clk_i)
    state == S_PEND ##1 state == S_DEACT);

endmodule : ntaf_fsm

//--- bench/ntaf_lt_model.sv
// Purpose: Behavioural line termination that feeds decoded line codes.
// Assumes: The bench picks the code sent and whether frame words are found.
// Notes:   Between ticks the match line toggles, so it never shows a stale
//          value that the block could wrongly rely on.
module ntaf_lt_model
  import ntaf_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Commands from the bench.
  input  wire ntaf_rxsig_t sig_i,
  input  wire logic        good_i,
  // Line receive side of the block.
  output ntaf_rxsig_t      line_rx_o,
  output logic             tick_o,
  output logic             match_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div;
  always_ff @(posedge clk_i) begin
    if (rst_i)
      div <= 2'h0;
    else
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
  end
  // One frame every three clocks keeps the loss test short.
  assign tick_o    = (div == 2'h2);
  assign match_o   = tick_o ? good_i : div[0];
  assign line_rx_o = sig_i;
endmodule : ntaf_lt_model

//--- bench/tb.sv
// Purpose: Self-checking bench for the activation state machine.
// Assumes: Timers and loss count shortened through parameters.
// Notes:   Inputs change at the falling edge; outputs are read one cycle on.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ntaf_pkg::*;
  localparam int TN1 = 20;
  localparam int T2  = 30;
  localparam int LS  = 60;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  ntaf_rxsig_t sig   = RX_SIG0;
  ntaf_uinfo_t ui    = UI_INFO0;
  logic        good  = 1'b1;
  logic        lost  = 1'b0;
  ntaf_rxsig_t line_rx;
  logic        tick;
  logic        match;
  ntaf_txsig_t line_tx;
  ntaf_uout_t  user_tx;
  logic        framed;
  logic        decho;
  logic        loop2;
  logic        traffic;
  logic [3:0]  state;
  int          fail_count  = 0;
  int          checks_done = 0;
  int          pick;

  always #50 clk_i = ~clk_i;

  ntaf_lt_model u_ntaf_lt_model (
    .clk_i(clk_i), .rst_i(rst_i), .sig_i(sig), .good_i(good),
    .line_rx_o(line_rx), .tick_o(tick), .match_o(match)
  );
  ntaf_fsm #(.TN1_CNT(TN1), .T2_CNT(T2), .LOSS(LS)) u_ntaf_fsm (
    .clk_i(clk_i), .rst_i(rst_i), .line_rx_i(line_rx),
    .line_frame_tick_i(tick), .line_frame_match_i(match),
    .user_rx_i(ui), .user_frame_lost_i(lost), .line_tx_o(line_tx),
    .user_tx_o(user_tx), .user_framed_o(framed), .decho_zero_o(decho),
    .loop_2bd_o(loop2), .traffic_o(traffic), .state_o(state)
  );

  function automatic ntaf_txsig_t exp_lt(input logic [3:0] st);
    case (st)
      4'h1, 4'h2:       return TX_SIG1W;
      4'h3:             return TX_SIG1A;
      4'h4:             return TX_SIG1;
      4'h5, 4'ha:       return TX_SIG3;
      4'h6, 4'h8, 4'hb: return TX_SIG5;
      default:          return TX_SIG0;
    endcase
  endfunction : exp_lt

  function automatic ntaf_uout_t exp_ut(input logic [3:0] st);
    case (st)
      4'h4, 4'h5, 4'h8, 4'ha: return UO_INFO2;
      4'h6, 4'hb:             return UO_INFO4;
      4'h9:                   return UO_INFOX;
      default:                return UO_INFO0;
    endcase
  endfunction : exp_ut

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic chk_all(input logic [3:0] st);
    ntaf_uout_t ut;
    ut = exp_ut(st);
    check(8'(state), 8'(st));
    check(8'(line_tx), 8'(exp_lt(st)));
    check(8'(user_tx), 8'(ut));
    check(8'(framed), 8'(ut == UO_INFO2 || ut == UO_INFO4));
    check(8'(decho), 8'(st == 4'hb));
    check(8'(loop2), 8'(st == 4'hb));
    check(8'(traffic), 8'(st == 4'h6));
  endtask : chk_all

  task automatic go(input ntaf_rxsig_t s, input ntaf_uinfo_t u);
    sig = s;
    ui  = u;
    @(negedge clk_i);
  endtask : go

  task automatic wait_st(input logic [3:0] st, input int lim);
    int n;
    n = 0;
    while (state !== st && n < lim) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_st

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h7b4e));
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    chk_all(4'h0);
    go(RX_NONE, UI_INFO1);
    chk_all(4'h1);
    go(RX_SIG2W, UI_INFO0);
    chk_all(4'h3);
    go(RX_SIG2, UI_INFO0);
    wait_st(4'h4, 40);
    chk_all(4'h4);
    go(RX_SIG2, UI_INFO3);
    chk_all(4'h5);
    go(RX_SIG4H, UI_INFO3);
    chk_all(4'h6);
    // Events that the active state must ignore, in random order.
    for (int i = 0; i < 16; i++) begin
      pick = $urandom % 3;
      go(pick == 0 ? RX_SIG4 : (pick == 1 ? RX_SIG4H : RX_NONE), UI_INFO3);
      chk_all(4'h6);
    end
    go(RX_SIG4, UI_INFO0);
    chk_all(4'h8);
    go(RX_SIG4, UI_INFO3);
    chk_all(4'h6);
    lost = 1'b1;
    go(RX_SIG4, UI_INFO3);
    chk_all(4'h8);
    lost = 1'b0;
    go(RX_SIG4, UI_INFO3);
    chk_all(4'h6);
    go(RX_SIG4L2, UI_INFO3);
    chk_all(4'hb);
    go(RX_SIG4, UI_INFO3);
    chk_all(4'h6);
    good = 1'b0;
    repeat (150) @(negedge clk_i);
    chk_all(4'h6);
    wait_st(4'h9, 90);
    chk_all(4'h9);
    // Regained framing alone must not leave the line-fault state.
    good = 1'b1;
    repeat (15) @(negedge clk_i);
    chk_all(4'h9);
    go(RX_SIG4L2, UI_INFO3);
    chk_all(4'hb);
    go(RX_SIG0, UI_OTHER);
    chk_all(4'h7);
    repeat (T2 - 3) @(negedge clk_i);
    chk_all(4'h7);
    wait_st(4'h0, 6);
    chk_all(4'h0);
    go(RX_SIG2W, UI_INFO1);
    chk_all(4'h2);
    go(RX_NONE, UI_INFO0);
    repeat (8) @(negedge clk_i);
    go(RX_SIG2W, UI_INFO0);
    go(RX_NONE, UI_INFO0);
    repeat (TN1 - 4) @(negedge clk_i);
    chk_all(4'h2);
    wait_st(4'h3, 6);
    chk_all(4'h3);
    go(RX_SIG2L2, UI_INFO0);
    wait_st(4'ha, 40);
    chk_all(4'ha);
    go(RX_SIG4HL2, UI_INFO0);
    chk_all(4'hb);
    go(RX_SIG4, UI_INFO3);
    chk_all(4'h6);
    go(RX_SIG0, UI_INFO0);
    chk_all(4'h7);
    go(RX_SIG0, UI_INFO0);
    chk_all(4'h0);
    // Loopback wait entered from line sync, left by a normal request.
    go(RX_SIG2W, UI_INFO0);
    go(RX_NONE, UI_INFO0);
    wait_st(4'h3, TN1 + 4);
    chk_all(4'h3);
    go(RX_SIG2, UI_INFO0);
    wait_st(4'h4, 40);
    chk_all(4'h4);
    go(RX_SIG2L2, UI_INFO0);
    chk_all(4'ha);
    go(RX_SIG4H, UI_INFO3);
    chk_all(4'h6);
    go(RX_SIG0, UI_INFO3);
    chk_all(4'h7);
    go(RX_SIG0, UI_INFO0);
    chk_all(4'h0);
    give_verdict();
  end
endmodule : tb
